// file: shared/aoc_pkg.sv
// Purpose: Constants and types for the converter calibration block
// Assumes: AHB-Lite register access, 32-bit data words
// Notes:   Offsets chosen for this block; one word per register
package aoc_pkg;

  // Register byte offsets
  localparam logic [7:0] AOC_OFF_MODE    = 8'h00;
  localparam logic [7:0] AOC_OFF_FILT    = 8'h04;
  localparam logic [7:0] AOC_OFF_CUR_CON = 8'h08;
  localparam logic [7:0] AOC_OFF_VLT_CON = 8'h0c;
  localparam logic [7:0] AOC_OFF_CUR_OF  = 8'h10;
  localparam logic [7:0] AOC_OFF_CUR_GN  = 8'h14;
  localparam logic [7:0] AOC_OFF_VLT_OF  = 8'h18;
  localparam logic [7:0] AOC_OFF_VLT_GN  = 8'h1c;
  localparam logic [7:0] AOC_OFF_CUR_RES = 8'h20;
  localparam logic [7:0] AOC_OFF_VLT_RES = 8'h24;

  // Field positions
  localparam int AOC_CHOP_BIT   = 15;
  localparam int AOC_DIAG_P_BIT = 14;
  localparam int AOC_DIAG_N_BIT = 13;
  localparam int AOC_UNI_BIT    = 4;

  // Reset values; factory coefficients stand in as parameters
  localparam logic [15:0] AOC_RST_FILT = 16'h0007;
  localparam logic [15:0] AOC_RST_OF   = 16'h0000;
  localparam logic [15:0] AOC_RST_GN   = 16'h5555;
  localparam logic [15:0] AOC_FS_POS   = 16'h7fff;
  localparam logic [15:0] AOC_FS_NEG   = 16'h8000;
  localparam int          AOC_GN_SHIFT = 14;

  // Output periods per conversion cycle
  localparam logic [1:0] AOC_PER_CHOP_OFF = 2'd3;
  localparam logic [1:0] AOC_PER_CHOP_ON  = 2'd2;

  typedef enum logic [2:0] {
    AOC_MD_IDLE     = 3'b000,
    AOC_MD_CONT     = 3'b001,
    AOC_MD_SINGLE   = 3'b010,
    AOC_MD_SELF_OF  = 3'b100,
    AOC_MD_SELF_GN  = 3'b101,
    AOC_MD_SYS_OF   = 3'b110,
    AOC_MD_SYS_GN   = 3'b111
  } aoc_mode_t;

  typedef enum logic [1:0] {
    AOC_PM_NORMAL = 2'b00,
    AOC_PM_LOW    = 2'b01,
    AOC_PM_LOWP   = 2'b10
  } aoc_pwr_t;

  // Analog input selection for the modulators
  typedef struct packed {
    logic zero_in;
    logic fs_in;
    logic ext_in;
  } aoc_insel_t;

  // Diagnostic current source enables
  typedef struct packed {
    logic cur_p;
    logic cur_n;
    logic vlt_sense;
    logic vlt_gnd;
  } aoc_diag_t;

endpackage

// file: hdl/aoc_calib.sv
// Purpose: Offset/gain calibration and correction for two converters
// Assumes: Filter samples arrive as 16-bit fractions with a valid strobe
// Notes:   Registers over AHB-Lite, answer with zero wait states
`timescale 1ns/1ps
module aoc_calib
  import aoc_pkg::*;
#(
  parameter logic [15:0] CUR_OF_FACTORY = 16'h0000,
  parameter logic [15:0] CUR_GN_FACTORY = 16'h5555,
  parameter logic [15:0] VLT_OF_FACTORY = 16'h0000,
  parameter logic [15:0] VLT_GN_FACTORY = 16'h5555
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Filter outputs, averaged when chopping
  input  wire logic        sample_valid,
  input  wire logic [15:0] cur_sample,
  input  wire logic [15:0] vlt_sample,
  // Power mode and reference choice
  input  wire aoc_pwr_t    pwr_mode,
  input  wire logic        half_supply_ref,
  // Analog controls
  output aoc_insel_t       insel,
  output aoc_diag_t        diag,
  output logic             conv_run,
  output logic      [3:0]  cur_gain_sel
);

  // Registers
  aoc_mode_t   mode;
  logic [15:0] filt;
  logic [15:0] cur_con;
  logic [15:0] vlt_con;
  logic [15:0] cur_of;
  logic [15:0] cur_gn;
  logic [15:0] vlt_of;
  logic [15:0] vlt_gn;
  logic [15:0] cur_res;
  logic [15:0] vlt_res;

  // Bus address phase capture
  logic        wr_pend;
  logic [7:0]  wr_addr;

  // Calibration sequencing
  logic [1:0]  per_cnt;
  logic        stage2;
  logic        in_cal;
  logic [15:0] zero_cur;
  logic [15:0] zero_vlt;

  wire logic  acc   = hsel && hready && htrans[1];
  wire logic  wr_en = wr_pend;
  wire logic  idle  = (mode == AOC_MD_IDLE);

  assign hresp     = 1'b0;
  assign hreadyout = 1'b1;

  function automatic logic is_cal(input aoc_mode_t m);
    is_cal = m[2];
  endfunction

  // Shift amount for K, as log2 of the factor
  function automatic logic [2:0] k_shift(input aoc_pwr_t p,
                                         input logic [3:0] g,
                                         input logic half);
    logic [2:0] s;
    s = 3'd0;
    unique case (p)
      AOC_PM_LOW:  s = 3'd5;
      AOC_PM_LOWP: s = 3'd3;
      default: begin
        unique case (g)
          4'd1, 4'd7: s = 3'd1;
          4'd8:       s = 3'd2;
          4'd9:       s = 3'd3;
          default:    s = 3'd0;
        endcase
      end
    endcase
    if (p != AOC_PM_NORMAL && half) begin
      s = 3'(s + 3'd1);
    end
    k_shift = s;
  endfunction

  // Subtract, scale by gain/16384, clamp; unipolar is offset binary
  function automatic logic [15:0] correct(input logic [15:0] x,
                                          input logic [15:0] of,
                                          input logic [2:0]  ks,
                                          input logic [15:0] gn,
                                          input logic        uni);
    logic signed [23:0] d;
    logic signed [41:0] p;
    logic signed [41:0] q;
    logic [15:0]        r;
    d = 24'($signed(x)) - (24'($signed(of)) <<< ks);
    p = 42'(d) * $signed({26'd0, gn});
    q = p >>> AOC_GN_SHIFT;
    if (q > 42'sd32767) begin
      r = AOC_FS_POS;
    end else if (q < -42'sd32768) begin
      r = AOC_FS_NEG;
    end else begin
      r = q[15:0];
    end
    correct = uni ? {~r[15], r[14:0]} : r;
  endfunction

  // Gain giving full scale from the measured span
  function automatic logic [15:0] gain_from(input logic [15:0] fs,
                                            input logic [15:0] zs);
    logic signed [16:0] span;
    logic [31:0]        g;
    span = 17'($signed(fs)) - 17'($signed(zs));
    if (span <= 17'sd0) begin
      g = 32'hffff;
    end else begin
      g = (32'd32767 << AOC_GN_SHIFT) / 32'(span);
    end
    gain_from = (g > 32'hffff) ? 16'hffff : g[15:0];
  endfunction

  wire logic [2:0] cur_k = k_shift(pwr_mode, cur_con[3:0],
                                   half_supply_ref);
  wire logic [1:0] periods = filt[AOC_CHOP_BIT] ? AOC_PER_CHOP_ON
                                                : AOC_PER_CHOP_OFF;
  wire logic cyc_done = sample_valid && (per_cnt == periods - 2'd1);
  wire logic is_gain  = mode[0];

  // Address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= acc && hwrite;
      if (acc) begin
        wr_addr <= haddr;
      end
    end
  end

  // Read data registered from the address-phase haddr
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (acc && !hwrite) begin
      unique case (haddr)
        AOC_OFF_MODE:    hrdata <= {29'd0, mode};
        AOC_OFF_FILT:    hrdata <= {16'd0, filt};
        AOC_OFF_CUR_CON: hrdata <= {16'd0, cur_con};
        AOC_OFF_VLT_CON: hrdata <= {16'd0, vlt_con};
        AOC_OFF_CUR_OF:  hrdata <= {16'd0, cur_of};
        AOC_OFF_CUR_GN:  hrdata <= {16'd0, cur_gn};
        AOC_OFF_VLT_OF:  hrdata <= {16'd0, vlt_of};
        AOC_OFF_VLT_GN:  hrdata <= {16'd0, vlt_gn};
        AOC_OFF_CUR_RES: hrdata <= {16'd0, cur_res};
        AOC_OFF_VLT_RES: hrdata <= {16'd0, vlt_res};
        default:         hrdata <= 32'h0;
      endcase
    end
  end

  // Configuration registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      filt    <= AOC_RST_FILT;
      cur_con <= 16'h0000;
      vlt_con <= 16'h0000;
    end else if (wr_en) begin
      if (wr_addr == AOC_OFF_FILT) begin
        filt <= hwdata[15:0];
      end
      if (wr_addr == AOC_OFF_CUR_CON) begin
        cur_con <= hwdata[15:0];
      end
      if (wr_addr == AOC_OFF_VLT_CON) begin
        vlt_con <= hwdata[15:0];
      end
    end
  end

  // Mode and calibration stage counting
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode    <= AOC_MD_IDLE;
      per_cnt <= 2'd0;
      stage2  <= 1'b0;
    end else if (wr_en && wr_addr == AOC_OFF_MODE) begin
      mode    <= aoc_mode_t'(hwdata[2:0]);
      per_cnt <= 2'd0;
      stage2  <= 1'b0;
    end else if (is_cal(mode) && sample_valid) begin
      if (!cyc_done) begin
        per_cnt <= per_cnt + 2'd1;
      end else begin
        per_cnt <= 2'd0;
        if (is_gain && !stage2) begin
          stage2 <= 1'b1;
        end else begin
          stage2 <= 1'b0;
          mode   <= AOC_MD_IDLE;
        end
      end
    end else if (mode == AOC_MD_SINGLE && sample_valid) begin
      mode <= AOC_MD_IDLE;
    end
  end

  assign in_cal = is_cal(mode);

  // Stage one of gain cal records the zero level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      zero_cur <= 16'h0;
      zero_vlt <= 16'h0;
    end else if (in_cal && is_gain && !stage2 && cyc_done) begin
      // System input holds full scale; zero comes from offset cal
      zero_cur <= mode[1] ? cur_of : cur_sample;
      zero_vlt <= mode[1] ? vlt_of : vlt_sample;
    end
  end

  // Coefficients
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur_of <= CUR_OF_FACTORY;
      cur_gn <= CUR_GN_FACTORY;
      vlt_of <= VLT_OF_FACTORY;
      vlt_gn <= VLT_GN_FACTORY;
    end else if (in_cal && cyc_done) begin
      if (!is_gain) begin
        cur_of <= cur_sample;
        vlt_of <= vlt_sample;
      end else if (stage2) begin
        cur_gn <= gain_from(cur_sample, zero_cur);
        vlt_gn <= gain_from(vlt_sample, zero_vlt);
      end
    end else if (wr_en && idle) begin
      // Busy-time writes are dropped to keep results coherent
      unique case (wr_addr)
        AOC_OFF_CUR_OF: cur_of <= hwdata[15:0];
        AOC_OFF_CUR_GN: cur_gn <= hwdata[15:0];
        AOC_OFF_VLT_OF: vlt_of <= hwdata[15:0];
        AOC_OFF_VLT_GN: vlt_gn <= hwdata[15:0];
        default: ;
      endcase
    end
  end

  // Corrected results, only from conversions
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur_res <= 16'h0;
      vlt_res <= 16'h0;
    end else if (!in_cal && !idle && sample_valid) begin
      cur_res <= correct(cur_sample, cur_of, cur_k, cur_gn,
                         cur_con[AOC_UNI_BIT]);
      vlt_res <= correct(vlt_sample, vlt_of, 3'd0, vlt_gn,
                         vlt_con[AOC_UNI_BIT]);
    end
  end

  // Analog control outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      insel        <= '0;
      diag         <= '0;
      conv_run     <= 1'b0;
      cur_gain_sel <= 4'd0;
    end else begin
      insel.zero_in <= (mode == AOC_MD_SELF_OF) ||
                       (mode == AOC_MD_SELF_GN && !stage2);
      insel.fs_in   <= (mode == AOC_MD_SELF_GN && stage2);
      insel.ext_in  <= !mode[2] || mode[1];
      diag.cur_p     <= cur_con[AOC_DIAG_P_BIT];
      diag.cur_n     <= cur_con[AOC_DIAG_N_BIT];
      diag.vlt_sense <= vlt_con[AOC_DIAG_P_BIT];
      diag.vlt_gnd   <= vlt_con[AOC_DIAG_N_BIT];
      conv_run <= !idle;
      unique case (pwr_mode)
        AOC_PM_LOW:  cur_gain_sel <= 4'd7;
        AOC_PM_LOWP: cur_gain_sel <= 4'd9;
        default:     cur_gain_sel <= cur_con[3:0];
      endcase
    end
  end

endmodule

// file: test/aoc_calib_sva.sv
// Purpose: Port assertions for aoc_calib
// Assumes: Single-word AHB-Lite writes
// Notes:   Mode, chop and control bits are shadowed from writes
`timescale 1ns/1ps
module aoc_calib_sva
  import aoc_pkg::*;
(
  // Bus side
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [7:0]  haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hreadyout,
  // Converter side
  input wire logic        sample_valid,
  input wire aoc_pwr_t    pwr_mode,
  input wire aoc_insel_t  insel,
  input wire aoc_diag_t   diag,
  input wire logic        conv_run,
  input wire logic [3:0]  cur_gain_sel
);
  logic       wp;
  logic [7:0] wa;
  logic [2:0] md;
  logic       chop;
  logic [1:0] vc;
  logic [3:0] np;
  logic [3:0] lim;
  logic [2:0] expi;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  assign lim = (chop ? 4'd2 : 4'd3) << md[0];
  assign expi = md[1] ? 3'b001 :
                (md[0] && np >= (chop ? 4'd2 : 4'd3)) ? 3'b010 : 3'b100;
  // Saturates so a long idle cannot wrap back onto the limit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wp <= 1'b0;
      wa <= 8'h00;
      md <= 3'h0;
      chop <= 1'b0;
      vc <= 2'h0;
      np <= 4'h0;
    end else begin
      wp <= hsel & htrans[1] & hwrite & hreadyout;
      wa <= haddr;
      if (wp && wa == AOC_OFF_MODE) begin
        md <= hwdata[2:0];
        np <= 4'h0;
      end else if (sample_valid && md[2] && np != 4'hf) begin
        np <= np + 4'h1;
      end
      if (wp && wa == AOC_OFF_FILT) begin
        chop <= hwdata[AOC_CHOP_BIT];
      end
      if (wp && wa == AOC_OFF_VLT_CON) begin
        vc <= hwdata[14:13];
      end
    end
  end
  sequence s_mode_wr;
    wp && wa == AOC_OFF_MODE;
  endsequence
  sequence s_cal_done;
    md[2] && np == lim;
  endsequence
  a_cal_starts: assert property (
    s_mode_wr ##0 hwdata[2] |-> ##[1:2] conv_run)
    else $error("calibration did not start");
  a_idle_stop: assert property (
    s_mode_wr ##0 hwdata[2:0] == 3'h0 |-> ##[1:2] !conv_run)
    else $error("idle write did not stop converter");
  a_cal_bound: assert property (
    conv_run && md[2] |-> np <= lim)
    else $error("calibration ran past its periods");
  a_cal_ends: assert property (
    s_cal_done |-> ##[1:3] !conv_run)
    else $error("calibration did not return to idle");
  a_input_select: assert property (
    md[2] && conv_run && sample_valid && $past(md, 2) == md
    |-> insel == expi)
    else $error("wrong modulator input during calibration");
  a_low_gain: assert property (
    (pwr_mode == AOC_PM_LOW) [*2] |=> cur_gain_sel == 4'd7)
    else $error("low power gain not 128");
  a_lowp_gain: assert property (
    (pwr_mode == AOC_PM_LOWP) [*2] |=> cur_gain_sel == 4'd9)
    else $error("low power plus gain not 512");
  a_diag_follow: assert property (
    wp && wa == AOC_OFF_VLT_CON
    |=> ##[0:1] {diag.vlt_sense, diag.vlt_gnd} == vc)
    else $error("voltage diagnostic sources wrong");
endmodule
bind aoc_calib aoc_calib_sva chk_i (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hreadyout(hreadyout), .sample_valid(sample_valid),
  .pwr_mode(pwr_mode), .insel(insel), .diag(diag),
  .conv_run(conv_run), .cur_gain_sel(cur_gain_sel)
);

// file: test/aoc_front.sv
// Purpose: Analog front end and filter model
// Assumes: One sample pulse every PER clocks
// Notes:   Samples are only meaningful in the pulse cycle
`timescale 1ns/1ps
module aoc_front
  import aoc_pkg::*;
#(
  parameter int          PER  = 8,
  parameter logic [15:0] ZERO = 16'h0040,
  parameter logic [15:0] FS   = 16'h6000
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Input choice and external levels
  input  wire aoc_insel_t  insel,
  input  wire logic [15:0] ext_cur,
  input  wire logic [15:0] ext_vlt,
  // Filter outputs
  output logic             sample_valid,
  output logic      [15:0] cur_sample,
  output logic      [15:0] vlt_sample
);
  int          cnt;
  logic [15:0] vc;
  logic [15:0] vv;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 0;
      sample_valid <= 1'b0;
      vc <= 16'h0000;
      vv <= 16'h0000;
    end else begin
      cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
      sample_valid <= (cnt == PER - 1);
      vc <= insel.zero_in ? ZERO : insel.fs_in ? FS : ext_cur;
      vv <= insel.ext_in ? ext_vlt : insel.fs_in ? FS : ZERO;
    end
  end
  // Stale values would let a late read pass by luck
  assign cur_sample = sample_valid ? vc : ~vc;
  assign vlt_sample = sample_valid ? vv : ~vv;
endmodule

// file: test/tb_aoc_calib.sv
// Purpose: Self-checking bench for aoc_calib
// Assumes: Zero wait-state slave, sample every 8 clocks
// Notes:   Integer model recomputes every result read back
`timescale 1ns/1ps
module tb_aoc_calib;
  import aoc_pkg::*;
  localparam int ZL  = 64;
  localparam int FSL = 24576;
  logic        hclk, hresetn, hsel, hwrite, sample_valid;
  logic        hreadyout, hresp, half_supply_ref, conv_run, u;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, q;
  logic [15:0] cur_sample, vlt_sample, ext_cur, ext_vlt, gn;
  logic [3:0]  cur_gain_sel, g;
  wire logic   hready;
  aoc_pwr_t    pwr_mode;
  aoc_insel_t  insel;
  aoc_diag_t   diag;
  int          n_errors, samples_checked, seed, cyc, np, ns, o, ez;
  logic [1:0]  dc;
  logic [31:0] exp_q[$];
  // Full-scale code times the gain divisor
  localparam longint GN_NUM = 32767 * 16384;
  assign hready = hreadyout;
  aoc_calib #(
    .CUR_OF_FACTORY(16'h0123),
    .VLT_GN_FACTORY(16'h4321)
  ) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .sample_valid(sample_valid),
    .cur_sample(cur_sample), .vlt_sample(vlt_sample),
    .pwr_mode(pwr_mode), .half_supply_ref(half_supply_ref),
    .insel(insel), .diag(diag), .conv_run(conv_run),
    .cur_gain_sel(cur_gain_sel)
  );
  aoc_front #(.ZERO(16'(ZL)), .FS(16'(FSL))) fe (
    .hclk(hclk), .hresetn(hresetn), .insel(insel),
    .ext_cur(ext_cur), .ext_vlt(ext_vlt), .sample_valid(sample_valid),
    .cur_sample(cur_sample), .vlt_sample(vlt_sample)
  );
  task automatic conclude();
    $display("checked=%0d errors=%0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
    chk(hresp, 1'b0);
  endtask
  function automatic int kf(int g, int i);
    if (i >= 10) return (i[0] ? 3 : 5) + i[1];
    return (g == 1 || g == 7) ? 1 : (g == 8) ? 2 : (g == 9) ? 3 : 0;
  endfunction
  function automatic logic [15:0] res(logic signed [15:0] x, int o, int k,
                                      logic [15:0] gn, logic u);
    longint r;
    r = ((longint'(x) - (longint'(o) <<< k)) * longint'(gn)) >>> 14;
    if (r > 32767) r = 32767;
    if (r < -32768) r = -32768;
    return r[15:0] ^ {u, 15'h0};
  endfunction
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc++;
    if (sample_valid) ns++;
    if (cyc == 20000) begin
      n_errors++;
      conclude();
    end
  end
  initial begin
    seed = 22;
    {hresetn, hsel, hwrite, haddr, htrans, hwdata} = '0;
    hsize = 3'b010;
    pwr_mode = AOC_PM_NORMAL;
    half_supply_ref = 1'b0;
    {ext_cur, ext_vlt} = '0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rd(AOC_OFF_CUR_OF, 32'h0123);
    rd(AOC_OFF_VLT_GN, 32'h4321);
    rd(AOC_OFF_CUR_GN, 32'h5555);
    rd(AOC_OFF_FILT, 32'h0007);
    rd(AOC_OFF_MODE, 32'h0);
    rd(8'h30, 32'h0);
    for (int m = 4; m < 8; m++) begin
      // System gain reuses the offset left by the system zero pass
      if (m != 7) ez = $random(seed) % 256;
      wr(AOC_OFF_FILT, m[0] ? 32'h8007 : 32'h0007);
      wr(AOC_OFF_CUR_GN, 32'h5555);
      ext_cur <= (m == 7) ? 16'(FSL) : 16'(ez);
      @(posedge hclk iff sample_valid);
      wr(AOC_OFF_MODE, 32'(m));
      np = ns;
      do bus(1'b0, AOC_OFF_MODE, 32'h0); while (q[2:0] !== 3'h0);
      chk(ns - np, (m[0] ? 2 : 3) << m[0]);
      if (m == 4) rd(AOC_OFF_CUR_OF, ZL);
      if (m == 5) rd(AOC_OFF_CUR_GN, 32'(GN_NUM / (FSL - ZL)));
      if (m == 6) rd(AOC_OFF_CUR_OF, {16'h0, 16'(ez)});
      if (m == 7) rd(AOC_OFF_CUR_GN, 32'(GN_NUM / (FSL - ez)));
      chk(conv_run, 1'b0);
    end
    for (int i = 0; i < 14; i++) begin
      g = (i < 10) ? 4'(i) : 4'($unsigned($random(seed)) % 10);
      u = 1'($random(seed));
      o = $random(seed) % 64;
      gn = 16'($random(seed));
      pwr_mode <= (i < 10) ? AOC_PM_NORMAL : aoc_pwr_t'(1 + i[0]);
      half_supply_ref <= i[1];
      ext_cur <= 16'($random(seed));
      ext_vlt <= 16'($random(seed));
      wr(AOC_OFF_MODE, 32'h0);
      dc = {g != 0 && i[0], g != 0 && i[2]};
      wr(AOC_OFF_CUR_CON, {17'h0, dc, 8'h0, u, g});
      wr(AOC_OFF_VLT_CON, {17'h0, i[1], i[2], 8'h0, u, 4'h0});
      wr(AOC_OFF_CUR_OF, {16'h0, 16'(o)});
      wr(AOC_OFF_VLT_OF, {16'h0, 16'(o)});
      wr(AOC_OFF_CUR_GN, {16'h0, gn});
      wr(AOC_OFF_VLT_GN, {16'h0, gn});
      wr(AOC_OFF_MODE, 32'h1);
      wr(AOC_OFF_CUR_OF, 32'h0);
      repeat (24) @(posedge hclk);
      exp_q.push_back({16'h0, res(ext_cur, o, kf(g, i), gn, u)});
      exp_q.push_back({16'h0, res(ext_vlt, o, 0, gn, u)});
      rd(AOC_OFF_CUR_OF, {16'h0, 16'(o)});
      rd(AOC_OFF_CUR_RES, exp_q.pop_front());
      rd(AOC_OFF_VLT_RES, exp_q.pop_front());
      chk(cur_gain_sel, (i < 10) ? g : i[0] ? 4'd9 : 4'd7);
      chk(diag, {dc, i[1], i[2]});
    end
    // Single conversion: one result, then back to idle
    wr(AOC_OFF_MODE, 32'h0);
    ext_cur <= 16'($random(seed));
    @(posedge hclk iff sample_valid);
    wr(AOC_OFF_MODE, 32'h2);
    do bus(1'b0, AOC_OFF_MODE, 32'h0); while (q[2:0] !== 3'h0);
    rd(AOC_OFF_CUR_RES, {16'h0, res(ext_cur, o, kf(g, 13), gn, u)});
    conclude();
  end
endmodule
